// ==== tb/rtcif_core_monitor.sv ====
// Assertion checker for the indirect access interface core.
// Assumes it is bound to rtcif_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rtcif_core_monitor (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_we,
    input wire logic       sfr_re,
    input wire logic [7:0] sfr_rdata,
    input wire logic       busy,
    input wire logic [1:0] interface_lock_state
);
    wire logic [1:0] st = interface_lock_state;
    wire logic       kw = sfr_we && sfr_addr == 8'hae;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    first_key_a: assert property (kw && sfr_wdata == 8'ha5 && st == 2'h0 |=> st == 2'h1)
        else $error("first key not taken");
    second_key_a: assert property (kw && sfr_wdata == 8'hf1 && st == 2'h1 |=> st == 2'h2)
        else $error("second key not taken");
    bad_key_a: assert property (kw && sfr_wdata != 8'hf1 && st == 2'h1 |=> st == 2'h3)
        else $error("wrong key did not disable");
    relock_a: assert property (kw && st == 2'h2 |=> st == 2'h0)
        else $error("key write did not relock");
    dead_lock_a: assert property (st == 2'h3 |=> st == 2'h3)
        else $error("left disabled state");
    locked_write_a: assert property (sfr_we && sfr_addr == 8'had && st < 2'h2 |=> st == 2'h3)
        else $error("locked data write did not disable");
    key_read_a: assert property (sfr_re && sfr_addr == 8'hae && !sfr_we
        |=> sfr_rdata == {6'h00, $past(st)} && $stable(st))
        else $error("key read wrong");
    read_start_a: assert property (sfr_we && sfr_addr == 8'hac && sfr_wdata[7]
        && st == 2'h2 && !busy |=> busy)
        else $error("busy set did not start read");
    write_start_a: assert property (sfr_we && sfr_addr == 8'had && st == 2'h2
        && !busy |=> busy)
        else $error("data write did not start");
    busy_len_a: assert property ($rose(busy) |-> busy[*6] ##1 (!busy || busy ##1 !busy))
        else $error("access length wrong");
endmodule
bind rtcif_core rtcif_core_monitor u_mon (.clock, .rst_n, .sfr_addr, .sfr_wdata, .sfr_we,
    .sfr_re, .sfr_rdata, .busy, .interface_lock_state);
`default_nettype wire

// ==== tb/rtcif_host.sv ====
// Processor side model issuing special function register accesses.
// Assumes inputs change at falling edges and strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none
module rtcif_host (
    input  wire logic       clock,
    input  wire logic       busy,
    input  wire logic [7:0] sfr_rdata,
    output var  logic [7:0] sfr_addr,
    output var  logic [7:0] sfr_wdata,
    output var  logic       sfr_we,
    output var  logic       sfr_re
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_we = 1'b0;
        sfr_re = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_we = 1'b1;
        @(negedge clock);
        sfr_we = 1'b0;
        // Stale data would hide a late sample
        sfr_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_re = 1'b1;
        @(negedge clock);
        sfr_re = 1'b0;
        d = sfr_rdata;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            @(negedge clock);
            n++;
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/test_rtcif_core.sv ====
// Self-checking bench for the indirect access interface core.
// Assumes the host model drives all bus inputs.
`timescale 1ns/1ps
`default_nettype none
module test_rtcif_core;
    logic        clock;
    logic        rst_n;
    wire  [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    wire         sfr_we, sfr_re, busy;
    wire  [1:0]  interface_lock_state;
    wire  [31:0] timer_capture_bytes, alarm_value_bytes;
    wire  [7:0]  clock_control, oscillator_control, oscillator_configuration, pin_configuration;
    int          bad_count, checked, i, n;
    logic [7:0]  r;
    rtcif_core DUT (.clock, .rst_n, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_re, .sfr_rdata,
        .busy, .interface_lock_state, .timer_capture_bytes, .alarm_value_bytes,
        .clock_control, .oscillator_control, .oscillator_configuration, .pin_configuration);
    rtcif_host host (.clock, .busy, .sfr_rdata, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_re);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, r);
        chk(r, e);
    endtask
    task automatic wd(input logic [7:0] d);
        host.wr(8'had, d);
        host.wait_idle;
    endtask
    task automatic span;
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            n++;
            @(negedge clock);
        end
    endtask
    task automatic reset;
        @(negedge clock);
        rst_n = 1'b0;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
    endtask
    task automatic unlock;
        host.wr(8'hae, 8'ha5);
        host.wr(8'hae, 8'hf1);
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        results;
    end
    initial begin
        rst_n = 1'b0;
        bad_count = 0;
        checked = 0;
        reset;
        rc(8'hae, 8'h00);
        rc(8'hac, 8'h00);
        host.wr(8'hae, 8'ha5);
        rc(8'hae, 8'h01);
        host.wr(8'hae, 8'hf1);
        rc(8'hae, 8'h02);
        host.rd(8'hac, r);
        chk(r & 8'hf0, 8'h10);
        $display("Unlock test done");
        host.wr(8'hac, 8'h10);
        for (i = 0; i < 8; i++) begin
            if (i == 4)
                host.wr(8'hac, 8'h18);
            wd(8'(17 * (i + 1)));
        end
        chk(timer_capture_bytes, 32'h44332211);
        chk(alarm_value_bytes, 32'h88776655);
        rc(8'hac, 8'h1c);
        for (i = 4; i < 8; i++) begin
            host.wr(8'hac, 8'(8'h10 + i));
            wd(8'(8'ha0 + i));
        end
        chk({clock_control, oscillator_control, oscillator_configuration, pin_configuration},
            32'ha4a5a6a7);
        rc(8'hac, 8'h17);
        $display("Write test done");
        host.wr(8'hac, 8'h85);
        span;
        chk(n, 7);
        host.wr(8'hac, 8'h95);
        span;
        chk(n, 6);
        rc(8'had, 8'ha5);
        rc(8'had, 8'ha5);
        host.wr(8'hac, 8'hd0);
        for (i = 0; i < 4; i++) begin
            host.wait_idle;
            rc(8'had, 8'(17 * (i + 1)));
        end
        host.wait_idle;
        $display("Read test done");
        host.wr(8'hac, 8'h06);
        wd(8'h5a);
        reset;
        unlock;
        rc(8'hac, 8'h16);
        rc(8'had, 8'h5a);
        host.wr(8'hae, 8'h3c);
        rc(8'hae, 8'h00);
        host.wr(8'had, 8'h77);
        rc(8'hae, 8'h03);
        host.wr(8'hae, 8'ha5);
        rc(8'hae, 8'h03);
        rc(8'hac, 8'h00);
        reset;
        host.wr(8'hae, 8'ha5);
        host.wr(8'hae, 8'ha5);
        rc(8'hae, 8'h03);
        $display("Lock test done");
        results;
    end
endmodule
`default_nettype wire

// ==== verilog/rtcif_core.v ====
// Lock and key, address and data registers with the indirect access engine.
// Assumes one-cycle sfr_we / sfr_re strobes synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
`include "rtcif_map.vh"
module rtcif_core (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wdata,
    input  wire        sfr_we,
    input  wire        sfr_re,
    output reg  [7:0]  sfr_rdata,
    output wire        busy,
    output wire [1:0]  interface_lock_state,
    output wire [31:0] timer_capture_bytes,
    output wire [31:0] alarm_value_bytes,
    output wire [7:0]  clock_control,
    output wire [7:0]  oscillator_control,
    output wire [7:0]  oscillator_configuration,
    output wire [7:0]  pin_configuration
);
    // Lock states, one-hot
    localparam [3:0] LK_LOCKED   = 4'h1;
    localparam [3:0] LK_FIRST    = 4'h2;
    localparam [3:0] LK_UNLOCKED = 4'h4;
    localparam [3:0] LK_DISABLED = 4'h8;

    // Access engine states, one-hot
    localparam [2:0] AC_IDLE  = 3'h1;
    localparam [2:0] AC_READ  = 3'h2;
    localparam [2:0] AC_WRITE = 3'h4;

    reg  [3:0] lock_q;
    reg  [3:0] lock_d;
    reg  [2:0] acc_q;
    reg  [2:0] acc_d;
    reg  [2:0] cnt_q;
    reg  [2:0] cnt_d;
    reg        auto_read_enable_q;
    reg        short_strobe_q;
    reg  [3:0] addr_q;
    reg  [7:0] data_q;

    wire       key_wr = sfr_we && (sfr_addr == `RTCIF_SFR_KEY);
    wire       adr_wr = sfr_we && (sfr_addr == `RTCIF_SFR_ADR);
    wire       dat_wr = sfr_we && (sfr_addr == `RTCIF_SFR_DAT);
    wire       adr_rd = sfr_re && (sfr_addr == `RTCIF_SFR_ADR);
    wire       dat_rd = sfr_re && (sfr_addr == `RTCIF_SFR_DAT);
    wire       key_rd = sfr_re && (sfr_addr == `RTCIF_SFR_KEY);

    wire       unlocked = (lock_q == LK_UNLOCKED);
    wire       disabled = (lock_q == LK_DISABLED);
    wire       engine_idle = (acc_q == AC_IDLE);

    // Indirect access requests as seen from the host
    wire       rd_req_busy = adr_wr && sfr_wdata[`RTCIF_ADR_BUSY];
    wire       rd_req_auto = dat_rd && auto_read_enable_q;
    wire       wr_req      = dat_wr;
    wire       any_req     = rd_req_busy || rd_req_auto || wr_req;

    // Accepted only when unlocked and the engine is free
    wire       start_rd = unlocked && engine_idle && (rd_req_busy || rd_req_auto);
    wire       start_wr = unlocked && engine_idle && wr_req && !start_rd;
    wire       done     = !engine_idle && (cnt_q == 3'h0);
    // A busy-setting write applies its own short bit to the read it starts
    wire       start_short = rd_req_busy ? sfr_wdata[`RTCIF_ADR_SHORT] : short_strobe_q;

    wire [7:0] ireg_rdata;
    wire       ireg_wr = done && (acc_q == AC_WRITE);

    // Capture and alarm bytes advance the address after each access
    wire       is_multi = (addr_q <= `RTCIF_IA_CAPTURE3) ||
                          ((addr_q >= `RTCIF_IA_ALARM0) && (addr_q <= `RTCIF_IA_ALARM3));

    // Lock and key sequence
    always @* begin
        lock_d = lock_q;
        case (lock_q)
            LK_LOCKED: begin
                if (key_wr) begin
                    if (sfr_wdata == `RTCIF_KEY_FIRST) begin
                        lock_d = LK_FIRST;
                    end else begin
                        lock_d = LK_DISABLED;
                    end
                end else if (any_req) begin
                    lock_d = LK_DISABLED;
                end
            end
            LK_FIRST: begin
                if (key_wr) begin
                    if (sfr_wdata == `RTCIF_KEY_SECOND) begin
                        lock_d = LK_UNLOCKED;
                    end else begin
                        lock_d = LK_DISABLED;
                    end
                end else if (any_req) begin
                    lock_d = LK_DISABLED;
                end
            end
            LK_UNLOCKED: begin
                // Stays open for any number of accesses
                if (key_wr) begin
                    lock_d = LK_LOCKED;
                end
            end
            LK_DISABLED: begin
                lock_d = LK_DISABLED;
            end
            default: begin
                lock_d = LK_DISABLED;
            end
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= LK_LOCKED;
        end else begin
            lock_q <= lock_d;
        end
    end

    // Access engine: counts the access length, then transfers
    always @* begin
        acc_d = acc_q;
        cnt_d = cnt_q;
        case (acc_q)
            AC_IDLE: begin
                if (start_rd || start_wr) begin
                    acc_d = start_rd ? AC_READ : AC_WRITE;
                    cnt_d = start_short ? (`RTCIF_CYC_SHORT - 3'h1)
                                        : (`RTCIF_CYC_LONG - 3'h1);
                end
            end
            AC_READ, AC_WRITE: begin
                if (cnt_q == 3'h0) begin
                    acc_d = AC_IDLE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            default: begin
                acc_d = AC_IDLE;
                cnt_d = 3'h0;
            end
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= AC_IDLE;
            cnt_q <= 3'h0;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
        end
    end

    // Mode bits of the address register, defined at reset
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            auto_read_enable_q <= 1'b0;
            short_strobe_q     <= `RTCIF_RST_SHORT;
        end else if (adr_wr && unlocked && engine_idle) begin
            auto_read_enable_q <= sfr_wdata[`RTCIF_ADR_AUTO_READ_ENABLE];
            short_strobe_q     <= sfr_wdata[`RTCIF_ADR_SHORT];
        end
    end

    // Address and data keep their contents through reset, so no reset term
    always @(posedge clock) begin
        if (adr_wr && unlocked && engine_idle) begin
            addr_q <= sfr_wdata[`RTCIF_ADR_MSB:0];
        end else if (done && is_multi) begin
            addr_q <= addr_q + 4'h1;
        end
    end

    always @(posedge clock) begin
        if (start_wr) begin
            data_q <= sfr_wdata;
        end else if (done && (acc_q == AC_READ)) begin
            data_q <= ireg_rdata;
        end
    end

    // Registered read port; disabled interface hides address and data
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= `RTCIF_BYTE_ZERO;
        end else if (key_rd) begin
            sfr_rdata <= {6'h00, interface_lock_state};
        end else if (adr_rd && unlocked) begin
            sfr_rdata <= {!engine_idle, auto_read_enable_q, 1'b0, short_strobe_q,
                          addr_q};
        end else if (dat_rd && unlocked) begin
            sfr_rdata <= data_q;
        end else if (sfr_re) begin
            sfr_rdata <= `RTCIF_BYTE_ZERO;
        end
    end

    assign busy = !engine_idle;

    assign interface_lock_state = (lock_q == LK_FIRST)    ? 2'h1 :
                                  (lock_q == LK_UNLOCKED) ? 2'h2 :
                                  disabled                ? 2'h3 : 2'h0;

    // Only path into the internal registers
    rtcif_regs #(
        .NUM_REGS (`RTCIF_IA_COUNT)
    ) u_regs (
        .clock                    (clock),
        .rst_n                    (rst_n),
        .wr_en                    (ireg_wr),
        .addr                     (addr_q),
        .wdata                    (data_q),
        .rdata                    (ireg_rdata),
        .capture_bytes            (timer_capture_bytes),
        .alarm_bytes              (alarm_value_bytes),
        .clock_control            (clock_control),
        .oscillator_control       (oscillator_control),
        .oscillator_configuration (oscillator_configuration),
        .pin_configuration        (pin_configuration)
    );
endmodule
`default_nettype wire

// ==== verilog/rtcif_map.vh ====
// Constants for the timekeeping unit's indirect access interface.
// Assumes single-cycle special function register strobes on the system clock.
`ifndef RTCIF_MAP_VH
`define RTCIF_MAP_VH

// Special function register addresses of the interface
`define RTCIF_SFR_ADR       8'hac
`define RTCIF_SFR_DAT       8'had
`define RTCIF_SFR_KEY       8'hae

// Key codes
`define RTCIF_KEY_FIRST     8'ha5
`define RTCIF_KEY_SECOND    8'hf1

// Lock status read codes
`define RTCIF_ST_LOCKED     8'h00
`define RTCIF_ST_FIRST      8'h01
`define RTCIF_ST_UNLOCKED   8'h02
`define RTCIF_ST_DISABLED   8'h03

// Address register fields
`define RTCIF_ADR_BUSY      7
`define RTCIF_ADR_AUTO_READ_ENABLE    6
`define RTCIF_ADR_SHORT     4
`define RTCIF_ADR_MSB       3

// Internal register addresses
`define RTCIF_IA_CAPTURE0   4'h0
`define RTCIF_IA_CAPTURE3   4'h3
`define RTCIF_IA_CLKCTL     4'h4
`define RTCIF_IA_OSCCTL     4'h5
`define RTCIF_IA_OSCCFG     4'h6
`define RTCIF_IA_PINCFG     4'h7
`define RTCIF_IA_ALARM0     4'h8
`define RTCIF_IA_ALARM3     4'hb
`define RTCIF_IA_COUNT      12

// Access lengths in system clocks
`define RTCIF_CYC_LONG      3'h7
`define RTCIF_CYC_SHORT     3'h6

`define RTCIF_BYTE_ZERO     8'h00
`define RTCIF_RST_SHORT     1'b1

`endif

// ==== verilog/rtcif_pad.v ====
// Holds no logic; pad ring lies outside this block.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verilog/rtcif_regs.v ====
// Internal byte registers of the timekeeping unit behind the indirect port.
// Assumes the access engine issues at most one read or write per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "rtcif_map.vh"
module rtcif_regs #(
    parameter NUM_REGS = `RTCIF_IA_COUNT
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        wr_en,
    input  wire [3:0]  addr,
    input  wire [7:0]  wdata,
    output wire [7:0]  rdata,
    output wire [31:0] capture_bytes,
    output wire [31:0] alarm_bytes,
    output wire [7:0]  clock_control,
    output wire [7:0]  oscillator_control,
    output wire [7:0]  oscillator_configuration,
    output wire [7:0]  pin_configuration
);
    reg [7:0] mem_q [0:NUM_REGS-1];

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g = g + 1) begin : g_byte
            localparam [3:0] IDX = g;
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[g] <= `RTCIF_BYTE_ZERO;
                end else if (wr_en && (addr == IDX)) begin
                    mem_q[g] <= wdata;
                end
            end
        end
    endgenerate

    // Unmapped addresses read as zero
    assign rdata = (addr < NUM_REGS) ? mem_q[addr] : `RTCIF_BYTE_ZERO;

    assign capture_bytes = {mem_q[3], mem_q[2], mem_q[1], mem_q[0]};
    assign alarm_bytes   = {mem_q[11], mem_q[10], mem_q[9], mem_q[8]};
    assign clock_control            = mem_q[`RTCIF_IA_CLKCTL];
    assign oscillator_control       = mem_q[`RTCIF_IA_OSCCTL];
    assign oscillator_configuration = mem_q[`RTCIF_IA_OSCCFG];
    assign pin_configuration        = mem_q[`RTCIF_IA_PINCFG];
endmodule
`default_nettype wire
